// *** rtl/scic_top.sv ***
`timescale 1ns/100ps
`include "scic_map.svh"

// Functional notes
// - Selector 00 analog (default), 01 duty input
// - Selector 11: software value via duty path
// - Command = (input minus bias) times scale
// - Scale signed; negative reverses direction
// - Scale units follow path and loop mode
// - Nonzero bias clips usable scale range
// - Bias in volts or duty, cancels source bias
// - Bias spans command range, tied to scale
// - Two cascaded single-pole filters, one corner
// - Corner settings in forbidden gap refused
// - Upper corner band leaves command unfiltered
// - Software value used only when selected; limited
// - Position mode ignores the software value
// - Software value not writable from network
// - Limits from model peak in current mode, else fixed
// - Factory +10 V gives full clockwise current
module scic_top #(
  parameter int IN_W  = 16,
  parameter int CMD_W = 24
) (
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_nrst,
  input  wire logic [`SCIC_ADDR_W-1:0]    i_addr,
  input  wire logic [31:0]                i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  input  wire logic                       i_wr_from_net,
  output logic      [31:0]                o_rdata,
  input  wire logic signed [IN_W-1:0]     i_analog_sample,
  input  wire logic                       i_analog_valid,
  input  wire logic                       i_duty_cycle_command_input,
  output logic signed [CMD_W-1:0]         o_scaled_loop_command,
  output scic_pkg::scic_ctrl_t            o_ctrl
);
  import scic_pkg::*;

  initial begin
    if (IN_W != 16 || CMD_W < 22 || CMD_W > 32) begin
      $error("scic_top: unsupported width parameters");
    end
  end

  localparam int DIV = `SCIC_SAMPLE_DIV;
  localparam int CW  = $clog2(DIV + 1);

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  scic_ctrl_t               ctrl_r;
  logic signed [15:0]       ana_scale_r;
  logic signed [15:0]       ana_bias_r;
  logic signed [15:0]       duty_scale_r;
  logic signed [15:0]       duty_bias_r;
  logic        [26:0]       corner_r;
  logic signed [15:0]       sw_cmd_r;
  logic                     refused_r;
  logic                     sat_r;
  logic                     corner_ok;
  logic                     bypass;
  logic        [26:0]       wr_corner;

  assign wr_corner = i_wdata[26:0];
  // Endpoints of the gap stay legal; only the interior is refused
  assign corner_ok = (wr_corner >= `SCIC_CORNER_MIN)
                   && (wr_corner <= `SCIC_CORNER_MAX)
                   && !((wr_corner > `SCIC_CORNER_GAP_LO)
                     && (wr_corner < `SCIC_CORNER_GAP_HI));

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_r       <= scic_ctrl_t'(`SCIC_CTRL_RST);
      ana_scale_r  <= `SCIC_SCALE_RST;
      ana_bias_r   <= `SCIC_BIAS_RST;
      duty_scale_r <= `SCIC_SCALE_RST;
      duty_bias_r  <= `SCIC_BIAS_RST;
      corner_r     <= `SCIC_CORNER_RST;
      sw_cmd_r     <= 16'h0000;
    end else if (i_wr) begin
      unique case (i_addr)
        `SCIC_REG_CTRL: begin
          ctrl_r <= scic_ctrl_t'(i_wdata[6:0]);
        end
        `SCIC_REG_ANA_SCALE:  ana_scale_r  <= i_wdata[15:0];
        `SCIC_REG_ANA_BIAS:   ana_bias_r   <= i_wdata[15:0];
        `SCIC_REG_DUTY_SCALE: duty_scale_r <= i_wdata[15:0];
        `SCIC_REG_DUTY_BIAS:  duty_bias_r  <= i_wdata[15:0];
        `SCIC_REG_CORNER: begin
          if (corner_ok) begin
            corner_r <= wr_corner;
          end
        end
        `SCIC_REG_SW_CMD: begin
          if (!i_wr_from_net) begin
            sw_cmd_r <= i_wdata[15:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Sticky refusal flag; a refusal in the clearing cycle wins
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      refused_r <= 1'b0;
    end else if (i_wr && i_addr == `SCIC_REG_CORNER && !corner_ok) begin
      refused_r <= 1'b1;
    end else if (i_wr && i_addr == `SCIC_REG_STATUS
                 && i_wdata[`SCIC_STAT_REFUSED]) begin
      refused_r <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      unique case (i_addr)
        `SCIC_REG_CTRL:       o_rdata <= {25'h0, ctrl_r};
        `SCIC_REG_ANA_SCALE:  o_rdata <= {16'h0, ana_scale_r};
        `SCIC_REG_ANA_BIAS:   o_rdata <= {16'h0, ana_bias_r};
        `SCIC_REG_DUTY_SCALE: o_rdata <= {16'h0, duty_scale_r};
        `SCIC_REG_DUTY_BIAS:  o_rdata <= {16'h0, duty_bias_r};
        `SCIC_REG_CORNER:     o_rdata <= {5'h0, corner_r};
        `SCIC_REG_SW_CMD:     o_rdata <= {16'h0, sw_cmd_r};
        `SCIC_REG_STATUS:     o_rdata <= {29'h0, bypass, sat_r, refused_r};
        `SCIC_REG_CMD_OUT: begin
          o_rdata <= 32'(o_scaled_loop_command);
        end
        default:              o_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  assign o_ctrl = ctrl_r;

  // ----------------------------------------------------------------------
  // Sample rate divider and input capture
  // ----------------------------------------------------------------------
  logic [CW-1:0]            div_r;
  logic                     smp_en;
  logic                     duty_meta_r;
  logic                     duty_sync_r;
  logic [CW-1:0]            high_cnt_r;
  logic signed [IN_W-1:0]   analog_r;
  logic signed [IN_W-1:0]   duty_x_r;
  logic [17:0]              duty_mul;

  assign smp_en = (div_r == CW'(DIV - 1));

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      div_r <= '0;
    end else begin
      div_r <= smp_en ? '0 : div_r + 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      duty_meta_r <= 1'b0;
      duty_sync_r <= 1'b0;
    end else begin
      duty_meta_r <= i_duty_cycle_command_input;
      duty_sync_r <= duty_meta_r;
    end
  end

  // High time over one sample window maps to a signed duty, 50 % near 0
  assign duty_mul = 18'(high_cnt_r * `SCIC_DUTY_MUL) >> 1;

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      high_cnt_r <= '0;
      duty_x_r   <= '0;
    end else if (smp_en) begin
      high_cnt_r <= CW'(duty_sync_r);
      duty_x_r   <= IN_W'(duty_mul - `SCIC_DUTY_CENTER);
    end else if (duty_sync_r) begin
      high_cnt_r <= high_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      analog_r <= '0;
    end else if (i_analog_valid) begin
      analog_r <= i_analog_sample;
    end
  end

  // ----------------------------------------------------------------------
  // Two cascaded single-pole low-pass stages
  // ----------------------------------------------------------------------
  logic [34:0]              alpha_full;
  logic [15:0]              alpha;
  logic signed [IN_W-1:0]   hw_x;
  logic signed [23:0]       stage_r [2];
  logic signed [23:0]       stage_in [2];
  logic signed [IN_W-1:0]   hw_filt;

  // Alpha approximates 2*pi*f*Ts in Q16 for the fixed sample period
  assign alpha_full = corner_r * `SCIC_ALPHA_K;
  assign alpha      = alpha_full[31:16];
  // Upper band needs no arithmetic; the stages are simply bypassed
  assign bypass     = (corner_r >= `SCIC_CORNER_GAP_HI);
  assign hw_x       = ctrl_r.command_source_select[0] ? duty_x_r : analog_r;
  assign stage_in[0] = {hw_x, 8'h00};
  assign stage_in[1] = stage_r[0];

  generate
    for (genvar s = 0; s < 2; s++) begin : g_stage
      logic signed [24:0] diff;
      logic signed [41:0] prod;
      assign diff = 25'(stage_in[s]) - 25'(stage_r[s]);
      assign prod = diff * $signed({1'b0, alpha});
      always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          stage_r[s] <= '0;
        end else if (smp_en) begin
          stage_r[s] <= stage_r[s] + prod[39:16];
        end
      end
    end
  endgenerate

  assign hw_filt = bypass ? hw_x : stage_r[1][23:8];

  // ----------------------------------------------------------------------
  // Offset, scale and limiting
  // ----------------------------------------------------------------------
  logic                     sw_sel;
  logic                     duty_path;
  logic                     pos_mode;
  logic signed [IN_W-1:0]   path_in;
  logic signed [15:0]       bias;
  logic signed [15:0]       scale;
  logic signed [16:0]       diff_in;
  logic signed [32:0]       prod_out;
  logic signed [CMD_W-1:0]  scaled;
  logic signed [CMD_W-1:0]  limit;
  logic                     over_pos;
  logic                     over_neg;

  assign sw_sel    = ctrl_r.command_source_select[1];
  assign duty_path = ctrl_r.command_source_select[0];
  assign pos_mode  = (ctrl_r.loop_operating_mode == SCIC_MODE_POSITION);

  always_comb begin
    if (sw_sel) begin
      path_in = pos_mode ? '0 : sw_cmd_r;
    end else begin
      path_in = hw_filt;
    end
  end

  assign bias     = duty_path ? duty_bias_r  : ana_bias_r;
  assign scale    = duty_path ? duty_scale_r : ana_scale_r;
  assign diff_in  = 17'(path_in) - 17'(bias);
  assign prod_out = diff_in * scale;
  assign scaled   = CMD_W'(prod_out >>> `SCIC_SCALE_FRAC);

  // Bus scale only rescales voltage-side figures outside this block
  always_comb begin
    if (ctrl_r.loop_operating_mode == SCIC_MODE_CURRENT) begin
      unique case (ctrl_r.model_peak)
        2'b00:   limit = CMD_W'(`SCIC_PEAK_4A5);
        2'b01:   limit = CMD_W'(`SCIC_PEAK_9A);
        default: limit = CMD_W'(`SCIC_PEAK_18A);
      endcase
    end else begin
      limit = CMD_W'(`SCIC_VEL_LIMIT);
    end
  end

  // Saturation is what narrows the usable scale once a bias is set
  assign over_pos = (scaled > limit);
  assign over_neg = (scaled < -limit);

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_scaled_loop_command <= '0;
      sat_r                 <= 1'b0;
    end else begin
      sat_r <= over_pos || over_neg;
      if (over_pos) begin
        o_scaled_loop_command <= limit;
      end else if (over_neg) begin
        o_scaled_loop_command <= -limit;
      end else begin
        o_scaled_loop_command <= scaled;
      end
    end
  end

endmodule : scic_top

// *** rtl/scic_map.svh ***
`ifndef SCIC_MAP_SVH
`define SCIC_MAP_SVH

// ----------------------------------------------------------------------
// Register indices (word index on the plain register port)
// ----------------------------------------------------------------------
`define SCIC_ADDR_W          4
`define SCIC_REG_CTRL        4'h0
`define SCIC_REG_ANA_SCALE   4'h1
`define SCIC_REG_ANA_BIAS    4'h2
`define SCIC_REG_DUTY_SCALE  4'h3
`define SCIC_REG_DUTY_BIAS   4'h4
`define SCIC_REG_CORNER      4'h5
`define SCIC_REG_SW_CMD      4'h6
`define SCIC_REG_STATUS      4'h7
`define SCIC_REG_CMD_OUT     4'h8

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define SCIC_CTRL_SRC_LSB    0
`define SCIC_CTRL_MODE_LSB   2
`define SCIC_CTRL_MODEL_LSB  4
`define SCIC_CTRL_QUART_BIT  6
`define SCIC_STAT_REFUSED    0
`define SCIC_STAT_SAT        1
`define SCIC_STAT_BYPASS     2
`define SCIC_CTRL_RST        7'h00
`define SCIC_SCALE_RST       16'h0233
`define SCIC_BIAS_RST        16'h0000
`define SCIC_SCALE_FRAC      12

// ----------------------------------------------------------------------
// Filter corner, in millihertz
// ----------------------------------------------------------------------
`define SCIC_CORNER_MIN      27'h00005EE
`define SCIC_CORNER_MAX      27'h58EF170
`define SCIC_CORNER_GAP_LO   27'h02C7AB8
`define SCIC_CORNER_GAP_HI   27'h17B8828
`define SCIC_CORNER_RST      27'h58EF170
`define SCIC_ALPHA_K         8'h87

// ----------------------------------------------------------------------
// Command limits and timing
// ----------------------------------------------------------------------
`define SCIC_PEAK_4A5        24'h001194
`define SCIC_PEAK_9A         24'h002328
`define SCIC_PEAK_18A        24'h004650
`define SCIC_VEL_LIMIT       24'h004786
`define SCIC_CLK_NS          5
`define SCIC_SAMPLE_NS       5000
`define SCIC_SAMPLE_DIV      (`SCIC_SAMPLE_NS / `SCIC_CLK_NS)
`define SCIC_DUTY_MUL        8'h83
`define SCIC_DUTY_CENTER     18'h07FEE

`endif

// *** rtl/scic_pkg.sv ***
package scic_pkg;

  typedef enum logic [1:0] {
    SCIC_SRC_ANALOG  = 2'b00,
    SCIC_SRC_DUTY    = 2'b01,
    SCIC_SRC_SW_ANA  = 2'b10,
    SCIC_SRC_SW_DUTY = 2'b11
  } scic_src_t;

  typedef enum logic [1:0] {
    SCIC_MODE_CURRENT  = 2'b00,
    SCIC_MODE_VELOCITY = 2'b01,
    SCIC_MODE_POSITION = 2'b10,
    SCIC_MODE_RSVD     = 2'b11
  } scic_mode_t;

  typedef struct packed {
    logic       bus_voltage_scale;
    logic [1:0] model_peak;
    scic_mode_t loop_operating_mode;
    scic_src_t  command_source_select;
  } scic_ctrl_t;

endpackage : scic_pkg

// *** dv/scic_chk.sv ***
`timescale 1ns/100ps
`include "scic_map.svh"

module scic_chk
  import scic_pkg::*;
#(
  parameter int IN_W  = 16,
  parameter int CMD_W = 24
) (
  input wire logic                    i_ref_clk,
  input wire logic                    i_nrst,
  input wire logic [`SCIC_ADDR_W-1:0] i_addr,
  input wire logic [31:0]             i_wdata,
  input wire logic                    i_wr,
  input wire logic                    i_rd,
  input wire logic                    i_wr_from_net,
  input wire logic [31:0]             o_rdata,
  input wire logic signed [IN_W-1:0]  i_analog_sample,
  input wire logic                    i_analog_valid,
  input wire logic                    i_duty_cycle_command_input,
  input wire logic signed [CMD_W-1:0] o_scaled_loop_command,
  input wire scic_pkg::scic_ctrl_t    o_ctrl
);
  int   cur_lim;
  logic sw_src;
  logic sw_wr;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  assign sw_src = o_ctrl.command_source_select[1];
  assign sw_wr  = i_wr && i_addr == `SCIC_REG_SW_CMD && sw_src;
  always_comb begin
    case (o_ctrl.model_peak)
      2'h0:    cur_lim = int'(`SCIC_PEAK_4A5);
      2'h1:    cur_lim = int'(`SCIC_PEAK_9A);
      default: cur_lim = int'(`SCIC_PEAK_18A);
    endcase
  end
  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  property p_rd_idle;
    !i_rd |=> o_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_ctrl_wr;
    i_wr && i_addr == `SCIC_REG_CTRL |=> o_ctrl == $past(i_wdata[6:0]);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr)
    else $error("ctrl write lost");
  property p_ctrl_hold;
    !(i_wr && i_addr == `SCIC_REG_CTRL) |=> $stable(o_ctrl);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold)
    else $error("ctrl moved");
  // Output lags the settings by one cycle, so settings must be steady
  property p_cur_lim;
    $stable(o_ctrl) && o_ctrl.loop_operating_mode == SCIC_MODE_CURRENT
      |-> o_scaled_loop_command <= cur_lim
       && o_scaled_loop_command >= -cur_lim;
  endproperty
  a_cur_lim: assert property (p_cur_lim) else $error("current limit");
  property p_vel_lim;
    $stable(o_ctrl) && o_ctrl.loop_operating_mode != SCIC_MODE_CURRENT
      |-> o_scaled_loop_command <= 18310 && o_scaled_loop_command >= -18310;
  endproperty
  a_vel_lim: assert property (p_vel_lim) else $error("speed limit");
  property p_net_drop;
    sw_wr && i_wr_from_net ##1 !i_wr |=> $stable(o_scaled_loop_command);
  endproperty
  a_net_drop: assert property (p_net_drop)
    else $error("net write used");
  property p_pos_ign;
    sw_wr && o_ctrl.loop_operating_mode == SCIC_MODE_POSITION ##1 !i_wr
      |=> $stable(o_scaled_loop_command);
  endproperty
  a_pos_ign: assert property (p_pos_ign)
    else $error("position uses sw");
  property p_corner_band;
    i_rd && i_addr == `SCIC_REG_CORNER
      |=> o_rdata >= `SCIC_CORNER_MIN && o_rdata <= `SCIC_CORNER_MAX;
  endproperty
  a_corner_band: assert property (p_corner_band)
    else $error("corner out");
  property p_corner_gap;
    i_rd && i_addr == `SCIC_REG_CORNER
      |=> !(o_rdata > `SCIC_CORNER_GAP_LO && o_rdata < `SCIC_CORNER_GAP_HI);
  endproperty
  a_corner_gap: assert property (p_corner_gap)
    else $error("corner in gap");
  c_net_drop: cover property (sw_wr && i_wr_from_net);
  c_pos_sw: cover property (sw_wr && o_ctrl.loop_operating_mode == 2'h2);
  c_corner_rd: cover property (i_rd && i_addr == `SCIC_REG_CORNER);
endmodule : scic_chk

// *** dv/scic_ctl_model.sv ***
`timescale 1ns/100ps

module scic_ctl_model (
  input  wire logic               i_ref_clk,
  input  wire logic               i_nrst,
  input  wire logic signed [15:0] i_level,
  input  wire logic [6:0]         i_high,
  input  wire logic [3:0]         i_gap,
  output logic signed [15:0]      o_sample,
  output logic                    o_valid,
  output logic                    o_pwm
);
  logic [6:0] pwm_cnt_r;
  logic [3:0] gap_cnt_r;
  // 2 MHz duty carrier keeps every legal corner far below a tenth of it
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pwm_cnt_r <= 7'h00;
      o_pwm     <= 1'b0;
    end else begin
      pwm_cnt_r <= (pwm_cnt_r == 7'h63) ? 7'h00 : pwm_cnt_r + 7'h01;
      o_pwm     <= pwm_cnt_r < i_high;
    end
  end
  // Between strobes the sample bus is scrambled, not held
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      gap_cnt_r <= 4'h0;
      o_valid   <= 1'b0;
      o_sample  <= 16'h0000;
    end else begin
      gap_cnt_r <= (gap_cnt_r >= i_gap) ? 4'h0 : gap_cnt_r + 4'h1;
      o_valid   <= gap_cnt_r >= i_gap;
      o_sample  <= (gap_cnt_r >= i_gap) ? i_level : ~i_level;
    end
  end
endmodule : scic_ctl_model

// *** dv/scic_top_bench.sv ***
`timescale 1ns/100ps
`include "scic_map.svh"

module scic_top_bench;
  import scic_pkg::*;
  logic                    i_ref_clk, i_nrst, i_wr, i_rd, i_wr_from_net;
  logic [`SCIC_ADDR_W-1:0] i_addr;
  logic [31:0]             i_wdata, o_rdata, rng, d;
  logic signed [15:0]      ana_sample, level, sw, ga, ba, gd, bd;
  logic                    ana_valid, pwm_pin;
  logic signed [23:0]      o_scaled_loop_command, ex;
  scic_ctrl_t              o_ctrl;
  logic [6:0]              high;
  logic [3:0]              gap;
  logic [1:0]              src, md, pk;
  int                      n_mismatch, tests_run;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic longint lim_of(input logic [1:0] m, input logic [1:0] p);
    if (m != SCIC_MODE_CURRENT) return `SCIC_VEL_LIMIT;
    if (p == 2'h0) return `SCIC_PEAK_4A5;
    return (p == 2'h1) ? `SCIC_PEAK_9A : `SCIC_PEAK_18A;
  endfunction : lim_of
  function automatic logic signed [23:0] exp_cmd(input logic signed [15:0] x,
    input logic signed [15:0] b, input logic signed [15:0] g, input longint l);
    longint p;
    p = ((longint'(x) - longint'(b)) * longint'(g)) >>> 12;
    p = (p > l) ? l : (p < -l) ? -l : p;
    return p[23:0];
  endfunction : exp_cmd

  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [31:0] v,
    input logic net = 1'b0);
    @(posedge i_ref_clk);
    i_wr          <= 1'b1;
    i_addr        <= a;
    i_wdata       <= v;
    i_wr_from_net <= net;
    @(posedge i_ref_clk);
    i_wr          <= 1'b0;
    i_wr_from_net <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge i_ref_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask : rd
  task automatic chk_word(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk_word
  task automatic chk_cmd(input string nm, input logic signed [23:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %0d got %0d", nm, e, g);
    end
  endtask : chk_cmd
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, string nm);
    logic [31:0] v;
    rd(a, v);
    chk_word(nm, e, v);
  endtask : rd_chk
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  scic_ctl_model u_ctl (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_level(level), .i_high(high), .i_gap(gap), .o_sample(ana_sample),
    .o_valid(ana_valid), .o_pwm(pwm_pin));
  scic_top uut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_wr_from_net(i_wr_from_net), .o_rdata(o_rdata),
    .i_analog_sample(ana_sample), .i_analog_valid(ana_valid),
    .i_duty_cycle_command_input(pwm_pin),
    .o_scaled_loop_command(o_scaled_loop_command), .o_ctrl(o_ctrl));

  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  // Run needs about 6.5k cycles; a hang is cut well beyond that
  initial begin
    repeat (40000) @(posedge i_ref_clk);
    n_mismatch++;
    complete_run();
  end

  initial begin
    {i_nrst, i_wr, i_rd, i_wr_from_net, i_addr, i_wdata} = '0;
    {level, high, n_mismatch, tests_run} = '0;
    rng = 32'h0000B7DD;
    gap = rng[3:0];
    repeat (4) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    tick(1);
    chk_word("ctrl", 32'h0, {25'h0, o_ctrl});
    chk_cmd("rst cmd", 24'h0, o_scaled_loop_command);
    rd_chk(`SCIC_REG_ANA_SCALE, 32'h233, "scale");
    rd_chk(`SCIC_REG_CORNER, 32'h058EF170, "corner");
    rd_chk(4'hC, 32'h0, "unmapped");
    @(posedge i_ref_clk) level <= 16'h7FFF;
    tick(40);
    chk_cmd("cw", `SCIC_PEAK_4A5, o_scaled_loop_command);
    @(posedge i_ref_clk) level <= 16'h8000;
    tick(40);
    chk_cmd("ccw", -`SCIC_PEAK_4A5, o_scaled_loop_command);
    for (int i = 0; i < 18; i++) begin
      rng = xs(rng);
      sw  = {{2{rng[13]}}, rng[13:0]};
      ba  = {{4{rng[29]}}, rng[29:18]};
      rng = xs(rng);
      {gd, ga} = rng;
      rng = xs(rng);
      bd  = {{4{rng[11]}}, rng[11:0]};
      pk  = rng[13:12];
      src = {1'b1, i[0]};
      md  = 2'(i >> 1);
      wr(`SCIC_REG_CTRL, {25'h0, rng[14], pk, md, src});
      wr(`SCIC_REG_ANA_SCALE, {16'h0, ga});
      wr(`SCIC_REG_ANA_BIAS, {16'h0, ba});
      wr(`SCIC_REG_DUTY_SCALE, {16'h0, gd});
      wr(`SCIC_REG_DUTY_BIAS, {16'h0, bd});
      wr(`SCIC_REG_SW_CMD, {16'h0, sw});
      wr(`SCIC_REG_SW_CMD, {16'h0, ~sw}, 1'b1);
      tick(3);
      ex = exp_cmd(md == 2'h2 ? 16'h0 : sw, src[0] ? bd : ba,
        src[0] ? gd : ga, lim_of(md, pk));
      chk_cmd("sw", ex, o_scaled_loop_command);
      rd(`SCIC_REG_SW_CMD, d);
      chk_word("sw kept", {16'h0, sw}, {16'h0, d[15:0]});
    end
    wr(`SCIC_REG_CORNER, 32'h00989680);
    rd_chk(`SCIC_REG_CORNER, 32'h058EF170, "gap");
    rd(`SCIC_REG_STATUS, d);
    chk_word("refused", 32'h1, {31'h0, d[0]});
    wr(`SCIC_REG_STATUS, 32'h1);
    rd(`SCIC_REG_STATUS, d);
    chk_word("cleared", 32'h0, {31'h0, d[0]});
    wr(`SCIC_REG_CORNER, `SCIC_CORNER_GAP_LO);
    wr(`SCIC_REG_CORNER, 32'h000005ED);
    rd_chk(`SCIC_REG_CORNER, `SCIC_CORNER_GAP_LO, "edge");
    wr(`SCIC_REG_CORNER, `SCIC_CORNER_MIN);
    wr(`SCIC_REG_CTRL, 32'h0);
    wr(`SCIC_REG_ANA_SCALE, 32'h233);
    wr(`SCIC_REG_ANA_BIAS, 32'h0);
    @(posedge i_ref_clk) level <= 16'h7FFF;
    tick(3000);
    chk_word("slow", 32'h1, {31'h0, o_scaled_loop_command < 4500});
    wr(`SCIC_REG_CORNER, `SCIC_CORNER_MAX);
    tick(40);
    chk_cmd("open", `SCIC_PEAK_4A5, o_scaled_loop_command);
    rd_chk(`SCIC_REG_STATUS, 32'h7, "status");
    rd_chk(`SCIC_REG_CMD_OUT, {8'h0, `SCIC_PEAK_4A5}, "cmd out");
    wr(`SCIC_REG_CTRL, 32'h1);
    wr(`SCIC_REG_DUTY_SCALE, 32'h233);
    wr(`SCIC_REG_DUTY_BIAS, 32'h0);
    @(posedge i_ref_clk) high <= 7'h4B;
    tick(3000);
    chk_cmd("duty", exp_cmd(16'h3FF7, 16'h0, 16'h233, 4500),
      o_scaled_loop_command);
    wr(`SCIC_REG_DUTY_BIAS, 32'h3FF7);
    tick(3);
    chk_cmd("bias", 24'h0, o_scaled_loop_command);
    complete_run();
  end
endmodule : scic_top_bench

bind scic_top scic_chk #(.IN_W(IN_W), .CMD_W(CMD_W)) u_chk (
  .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .i_wr_from_net(i_wr_from_net), .o_rdata(o_rdata),
  .i_analog_sample(i_analog_sample), .i_analog_valid(i_analog_valid),
  .i_duty_cycle_command_input(i_duty_cycle_command_input),
  .o_scaled_loop_command(o_scaled_loop_command), .o_ctrl(o_ctrl));
